// >>> sofc_pkg.sv
// Package of constants and types for the serial output framing configuration block
package sofc_pkg;

    // Register addresses on the serial control port
    localparam logic [14:0] A_FRAME_CLK = 15'h0019;
    localparam logic [14:0] A_DRIVE = 15'h001A;
    localparam logic [14:0] A_RES = 15'h001B;
    localparam logic [14:0] A_TIME = 15'h001E;
    localparam logic [7:0] RST_VAL = 8'h00;

    // Field positions
    localparam int B_SRC = 7;
    localparam int B_DIV = 4;
    localparam int B_STRETCH = 0;
    localparam int B_HALF = 6;
    localparam int B_MAPPER = 7;
    localparam int B_WIDE = 6;
    localparam int L_WIDTH_SEL = 3;
    localparam int L_DATA_SKEW = 2;
    localparam int L_CLK_SKEW = 0;

    // Decimation modes and lane counts from the data path
    localparam logic [1:0] DM_BYPASS = 2'h0;
    localparam logic [1:0] DM_REAL = 2'h1;
    localparam logic [1:0] DM_COMPLEX = 2'h2;
    localparam logic [1:0] LN_2W = 2'h0;
    localparam logic [1:0] LN_1W = 2'h1;
    localparam logic [1:0] LN_HALF = 2'h2;

    // Output width codes and widths
    localparam logic [2:0] WS_18 = 3'h0;
    localparam logic [2:0] WS_16 = 3'h1;
    localparam logic [2:0] WS_14 = 3'h2;
    localparam logic [4:0] W_20 = 5'h14;
    localparam logic [4:0] W_18 = 5'h12;
    localparam logic [4:0] W_16 = 5'h10;
    localparam logic [4:0] W_14 = 5'h0E;
    localparam logic [4:0] W_NATIVE = 5'h0E;

    // Drive current in microamps
    localparam logic [11:0] CUR_FULL_UA = 12'h0DAC;
    localparam logic [11:0] CUR_HALF_UA = 12'h06D6;

    // Skew in picoseconds, two's complement
    localparam logic [7:0] SKEW_STEP_PS = 8'h32;
    localparam logic [7:0] SKEW_NONE_PS = 8'h00;
    localparam logic [7:0] SKEW_ADV_PS = 8'hCE;
    localparam logic [7:0] SKEW_DEL_PS = 8'h32;
    localparam logic [7:0] SKEW_DEL2_PS = 8'h64;

    // Frame duty patterns applied automatically in bypass
    localparam logic [19:0] PAT_14 = 20'hF_E000;
    localparam logic [19:0] PAT_16 = 20'hF_F000;
    localparam logic [19:0] PAT_18 = 20'hF_F800;
    localparam logic [19:0] PAT_20 = 20'hF_FC00;

    // Serial control frame: 1 direction bit, 15 address bits, 8 data bits
    localparam logic [4:0] SP_ADDR_LAST = 5'h0F;
    localparam logic [4:0] SP_FRAME_LAST = 5'h17;

    typedef enum logic [1:0] {
        SP_IDLE = 2'b00,
        SP_CMD = 2'b01,
        SP_DATA = 2'b10,
        SP_DONE = 2'b11
    } sofc_spi_state_type;

endpackage

// >>> sofc_reg_if.sv
// Interface between the serial port shifter and the register bank
`timescale 1ns/100ps
`default_nettype none
interface sofc_reg_if;
    logic wr_stb;
    logic [14:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport shifter (output wr_stb, output addr, output wdata, input rdata);
    modport bank (input wr_stb, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// >>> sofc_spi_shifter.sv
// Serial control port shifter, sampled on the system clock
`timescale 1ns/100ps
`default_nettype none
module sofc_spi_shifter
    import sofc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_sclk,
    input wire logic i_sen_n,
    input wire logic i_sdio,
    sofc_reg_if.shifter bus,
    output logic o_sdout,
    output logic o_sdout_oe
);

    typedef struct packed {
        logic [2:0] sclk_s;
        logic [1:0] sen_s;
        logic [1:0] sdio_s;
        sofc_spi_state_type st;
        logic [4:0] cnt;
        logic rw;
        logic ld;
        logic [22:0] sh;
        logic [7:0] rd_sh;
        logic wr;
        logic [14:0] addr;
        logic [7:0] wdata;
        logic sdo;
        logic oe;
    } sofc_shift_type;

    sofc_shift_type q;
    sofc_shift_type d;

    always_comb
    begin
        logic rise;
        logic fall;
        logic [22:0] nsh;
        rise = q.sclk_s[1] & ~q.sclk_s[2];
        fall = ~q.sclk_s[1] & q.sclk_s[2];
        nsh = {q.sh[21:0], q.sdio_s[1]};
        d = q;
        d.sclk_s = {q.sclk_s[1:0], i_sclk};
        d.sen_s = {q.sen_s[0], i_sen_n};
        d.sdio_s = {q.sdio_s[0], i_sdio};
        d.wr = 1'b0;
        d.ld = 1'b0;
        // Read data sampled one cycle after the address settles
        if (q.ld)
        begin
            d.rd_sh = bus.rdata;
        end
        if (q.sen_s[1])
        begin
            d.st = SP_IDLE;
            d.cnt = 5'h00;
            d.oe = 1'b0;
        end
        else
        begin
            unique case (q.st)
                SP_IDLE:
                begin
                    d.st = SP_CMD;
                    d.cnt = 5'h00;
                end
                SP_CMD:
                begin
                    if (rise)
                    begin
                        d.sh = nsh;
                        d.cnt = q.cnt + 5'h01;
                        if (q.cnt == SP_ADDR_LAST)
                        begin
                            d.rw = nsh[15];
                            d.addr = nsh[14:0];
                            d.ld = 1'b1;
                            d.st = SP_DATA;
                        end
                    end
                end
                SP_DATA:
                begin
                    if (rise)
                    begin
                        d.sh = nsh;
                        d.cnt = q.cnt + 5'h01;
                        if (q.cnt == SP_FRAME_LAST)
                        begin
                            d.st = SP_DONE;
                            d.wr = ~q.rw;
                            d.wdata = nsh[7:0];
                        end
                    end
                    // Read bits leave on falling edges so the host samples on rising
                    if (fall && q.rw)
                    begin
                        d.sdo = q.rd_sh[7];
                        d.rd_sh = {q.rd_sh[6:0], 1'b0};
                        d.oe = 1'b1;
                    end
                end
                SP_DONE:
                begin
                    d.st = SP_DONE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            q <= '0;
            q.sen_s <= 2'h3;
            q.sclk_s <= 3'h0;
        end
        else
        begin
            q <= d;
        end
    end

    assign bus.wr_stb = q.wr;
    assign bus.addr = q.addr;
    assign bus.wdata = q.wdata;
    assign o_sdout = q.sdo;
    assign o_sdout_oe = q.oe;

endmodule
`default_nettype wire

// >>> sofc_config.sv
// Register bank and derived controls for the serial output framing
//
// Operation
// - Source select bit takes the frame clock from the core or down-conversion block.
// - Real decimation counts as bypass when judging frame clock configuration.
// - Stretch bit widens the frame clock over both channels on half-lane output.
// - Half-drive bit halves the output drive current.
// - Mapper enable allows width change in bypass; not needed for 20-bit output.
// - Wide-output enable selects a 20-bit output word.
// - Width code 000/001/010 gives 18/16/14 bits; others not applicable.
// - Data skew code gives none, 50 ps advance, 50 or 100 ps delay.
// - Bit clock skew code gives none, 50 ps advance, 50 or 100 ps delay.
// - In bypass the frame duty pattern follows the chosen output width.
`timescale 1ns/100ps
`default_nettype none
module sofc_config
    import sofc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_sclk,
    input wire logic i_sen_n,
    input wire logic i_sdio,
    input wire logic [1:0] i_decim_mode,
    input wire logic [1:0] i_lane_mode,
    input wire logic [19:0] i_user_duty_pattern,
    output logic o_sdout,
    output logic o_sdout_oe,
    output logic o_frame_clock_source_sel,
    output logic o_frame_clock_divide,
    output logic o_frame_clock_stretch,
    output logic o_half_drive_current,
    output logic [11:0] o_drive_current_ua,
    output logic [4:0] o_word_width,
    output logic o_width_code_valid,
    output logic [19:0] o_frame_duty_pattern,
    output logic [7:0] o_data_output_skew_ps,
    output logic [7:0] o_bit_clock_output_skew_ps,
    output logic o_config_mismatch
);

    typedef struct packed {
        logic [7:0] frame;
        logic [7:0] drive;
        logic [7:0] res;
        logic [7:0] timing;
        logic src;
        logic div;
        logic str;
        logic half;
        logic [11:0] cur;
        logic [4:0] width;
        logic wvalid;
        logic [19:0] pat;
        logic [7:0] dskew;
        logic [7:0] cskew;
        logic mism;
    } sofc_bank_type;

    sofc_bank_type q;
    sofc_bank_type d;
    sofc_reg_if bus ();

    sofc_spi_shifter u_shifter (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_sclk(i_sclk),
        .i_sen_n(i_sen_n),
        .i_sdio(i_sdio),
        .bus(bus),
        .o_sdout(o_sdout),
        .o_sdout_oe(o_sdout_oe)
    );

    function automatic logic [7:0] skew_ps(input logic [1:0] code);
        logic [7:0] v;
        v = SKEW_NONE_PS;
        unique case (code)
            2'h0: v = SKEW_NONE_PS;
            2'h1: v = SKEW_ADV_PS;
            2'h2: v = SKEW_DEL_PS;
            2'h3: v = SKEW_DEL2_PS;
        endcase
        return v;
    endfunction

    // Register read, full byte so reserved bits read back as written
    always_comb
    begin
        bus.rdata = 8'h00;
        unique case (bus.addr)
            A_FRAME_CLK: bus.rdata = q.frame;
            A_DRIVE: bus.rdata = q.drive;
            A_RES: bus.rdata = q.res;
            A_TIME: bus.rdata = q.timing;
            default: bus.rdata = 8'h00;
        endcase
    end

    always_comb
    begin
        logic bypass;
        logic use_mapper;
        logic cls_bypass;
        logic [2:0] wsel;
        logic [4:0] width;
        logic [19:0] auto_pat;
        bypass = 1'b0;
        use_mapper = 1'b0;
        cls_bypass = 1'b0;
        wsel = 3'h0;
        width = W_18;
        auto_pat = PAT_18;
        d = q;
        if (bus.wr_stb)
        begin
            unique case (bus.addr)
                A_FRAME_CLK: d.frame = bus.wdata;
                A_DRIVE: d.drive = bus.wdata;
                A_RES: d.res = bus.wdata;
                A_TIME: d.timing = bus.wdata;
                default: d.frame = q.frame;
            endcase
        end
        d.src = q.frame[B_SRC];
        d.div = q.frame[B_DIV];
        d.str = q.frame[B_STRETCH];
        d.half = q.drive[B_HALF];
        d.cur = q.drive[B_HALF] ? CUR_HALF_UA : CUR_FULL_UA;
        // Width chain
        bypass = (i_decim_mode == DM_BYPASS);
        wsel = q.res[L_WIDTH_SEL +: 3];
        use_mapper = ~bypass | q.res[B_MAPPER];
        d.wvalid = (wsel == WS_18) || (wsel == WS_16) || (wsel == WS_14);
        width = W_18;
        unique case (wsel)
            WS_16: width = W_16;
            WS_14: width = W_14;
            default: width = W_18;
        endcase
        if (q.res[B_WIDE])
        begin
            width = W_20;
        end
        else if (!use_mapper)
        begin
            width = W_NATIVE;
        end
        d.width = width;
        // Auto pattern tracks width; other modes keep the user pattern
        auto_pat = PAT_18;
        unique case (width)
            W_20: auto_pat = PAT_20;
            W_16: auto_pat = PAT_16;
            W_14: auto_pat = PAT_14;
            default: auto_pat = PAT_18;
        endcase
        d.pat = bypass ? auto_pat : i_user_duty_pattern;
        d.dskew = skew_ps(q.timing[L_DATA_SKEW +: 2]);
        d.cskew = skew_ps(q.timing[L_CLK_SKEW +: 2]);
        // Flag settings software should not have chosen; real is bypass here
        cls_bypass = (i_decim_mode == DM_BYPASS) || (i_decim_mode == DM_REAL);
        if (i_lane_mode == 2'h3 || i_decim_mode == 2'h3)
        begin
            d.mism = 1'b1;
        end
        else if (cls_bypass)
        begin
            d.mism = q.frame[B_SRC] || q.frame[B_STRETCH] || (q.frame[B_DIV] != (i_lane_mode == LN_2W));
        end
        else
        begin
            d.mism = (q.frame[B_SRC] != (i_lane_mode != LN_HALF)) || q.frame[B_DIV]
                || (q.frame[B_STRETCH] != (i_lane_mode == LN_HALF));
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            q <= '0;
            q.cur <= CUR_FULL_UA;
            q.width <= W_NATIVE;
            q.wvalid <= 1'b1;
            q.pat <= PAT_14;
        end
        else
        begin
            q <= d;
        end
    end

    assign o_frame_clock_source_sel = q.src;
    assign o_frame_clock_divide = q.div;
    assign o_frame_clock_stretch = q.str;
    assign o_half_drive_current = q.half;
    assign o_drive_current_ua = q.cur;
    assign o_word_width = q.width;
    assign o_width_code_valid = q.wvalid;
    assign o_frame_duty_pattern = q.pat;
    assign o_data_output_skew_ps = q.dskew;
    assign o_bit_clock_output_skew_ps = q.cskew;
    assign o_config_mismatch = q.mism;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    property p_src_write;
        (bus.wr_stb && bus.addr == A_FRAME_CLK) |-> ##2 (o_frame_clock_source_sel == $past(bus.wdata[B_SRC], 2));
    endproperty
    a_src_write: assert property (p_src_write) else $error("frame clock source not taken from write");

    property p_real_as_bypass;
        (q.frame == 8'h10 && i_decim_mode == DM_REAL && i_lane_mode == LN_2W) |=> !o_config_mismatch;
    endproperty
    a_real_as_bypass: assert property (p_real_as_bypass) else $error("real decimation not treated as bypass");

    property p_stretch;
        ##1 (o_frame_clock_stretch == $past(q.frame[B_STRETCH])) && (o_frame_clock_divide == $past(q.frame[B_DIV]));
    endproperty
    a_stretch: assert property (p_stretch) else $error("stretch or divide output lags its bit");

    property p_half_current;
        (bus.wr_stb && bus.addr == A_DRIVE) |-> ##2
            (o_drive_current_ua == ($past(bus.wdata[B_HALF], 2) ? CUR_HALF_UA : CUR_FULL_UA));
    endproperty
    a_half_current: assert property (p_half_current) else $error("drive current wrong after write");

    property p_native_bypass;
        (i_decim_mode == DM_BYPASS && q.res[B_MAPPER:B_WIDE] == 2'h0) |=> (o_word_width == W_NATIVE);
    endproperty
    a_native_bypass: assert property (p_native_bypass) else $error("bypass without mapper not native width");

    property p_wide;
        q.res[B_WIDE] |=> (o_word_width == W_20);
    endproperty
    a_wide: assert property (p_wide) else $error("wide output not 20 bits");

    property p_width16;
        (i_decim_mode == DM_COMPLEX && !q.res[B_WIDE] && q.res[L_WIDTH_SEL +: 3] == WS_16)
            |=> (o_word_width == W_16) && o_width_code_valid;
    endproperty
    a_width16: assert property (p_width16) else $error("width code 001 not 16 bits");

    property p_data_skew;
        (q.timing[L_DATA_SKEW +: 2] == 2'h3) [*2] |-> (o_data_output_skew_ps == SKEW_DEL2_PS);
    endproperty
    a_data_skew: assert property (p_data_skew) else $error("data skew code 11 not 100 ps");

    property p_clk_skew;
        (q.timing[L_CLK_SKEW +: 2] == 2'h1) [*2] |-> (o_bit_clock_output_skew_ps == SKEW_ADV_PS);
    endproperty
    a_clk_skew: assert property (p_clk_skew) else $error("clock skew code 01 not 50 ps advance");

    property p_auto_pattern;
        (i_decim_mode == DM_BYPASS && q.res[B_WIDE]) |=> (o_frame_duty_pattern == PAT_20);
    endproperty
    a_auto_pattern: assert property (p_auto_pattern) else $error("bypass pattern not tracking width");

    property p_reset_zero;
        @(posedge i_clk) disable iff (1'b0)
        $past(i_srst) |-> (q.frame == RST_VAL) && (q.drive == RST_VAL)
            && (q.res == RST_VAL) && (q.timing == RST_VAL);
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("register not zero after reset");

    property p_reserved_store;
        (bus.wr_stb && bus.addr == A_DRIVE) |=> (q.drive == $past(bus.wdata));
    endproperty
    a_reserved_store: assert property (p_reserved_store) else $error("written byte not stored whole");

    property p_width_invalid;
        (q.res[L_WIDTH_SEL +: 3] > WS_14) |=> !o_width_code_valid;
    endproperty
    a_width_invalid: assert property (p_width_invalid) else $error("unused width code flagged valid");

    property p_user_pattern;
        (i_decim_mode != DM_BYPASS) |=> (o_frame_duty_pattern == $past(i_user_duty_pattern));
    endproperty
    a_user_pattern: assert property (p_user_pattern) else $error("user pattern not passed outside bypass");

    property p_real_source;
        (i_decim_mode == DM_REAL && q.frame[B_SRC]) |=> o_config_mismatch;
    endproperty
    a_real_source: assert property (p_real_source) else $error("source select in real mode not flagged");

    property p_full_current;
        !q.drive[B_HALF] |=> (o_drive_current_ua == CUR_FULL_UA) && !o_half_drive_current;
    endproperty
    a_full_current: assert property (p_full_current) else $error("half bit clear but current not full");

    property p_data_advance;
        (q.timing[L_DATA_SKEW +: 2] == 2'h1) |=> (o_data_output_skew_ps == SKEW_ADV_PS);
    endproperty
    a_data_advance: assert property (p_data_advance) else $error("data skew code 01 not 50 ps advance");

    c_write_frame: cover property (bus.wr_stb && bus.addr == A_FRAME_CLK && bus.wdata[B_SRC]);
    c_read_seen: cover property (o_sdout_oe ##1 !o_sdout_oe);
    c_mismatch: cover property ($rose(o_config_mismatch));
    c_width14: cover property (o_word_width == W_14 && i_decim_mode == DM_REAL);
    c_half_lane_stretch: cover property (o_frame_clock_stretch && i_lane_mode == LN_HALF);

endmodule
`default_nettype wire

// >>> sofc_host_model.sv
// Serial control port host model that drives frames and captures read data
`timescale 1ns/100ps
`default_nettype none
module sofc_host_model
(
    input wire logic i_clk,
    input wire logic i_sdout,
    input wire logic i_sdout_oe,
    output logic o_sclk,
    output logic o_sen_n,
    output logic o_sdio,
    output logic [7:0] o_rdata,
    output logic o_rd_done
);
    initial
    begin
        o_sclk = 1'b0;
        o_sen_n = 1'b1;
        o_sdio = 1'b0;
        o_rdata = 8'h00;
        o_rd_done = 1'b0;
    end

    // Serial clock stands low between frames; 4 clk per phase gives 80 ns period
    task automatic xfer(input logic rd, input logic [14:0] addr, input logic [7:0] wdata);
        logic [23:0] frame;
        frame = {rd, addr, wdata};
        @(negedge i_clk);
        o_sen_n <= 1'b0;
        repeat (4) @(negedge i_clk);
        for (int i = 23; i >= 0; i--)
        begin
            // Data line is not ours in the read phase, so it toggles
            o_sdio <= (rd && i < 8) ? ~o_sdio : frame[i];
            repeat (4) @(negedge i_clk);
            o_sclk <= 1'b1;
            repeat (4) @(negedge i_clk);
            // Undriven output must not pass for data
            if (rd && i < 8)
                o_rdata[i] = i_sdout_oe ? i_sdout : ~i_sdout;
            o_sclk <= 1'b0;
        end
        repeat (4) @(negedge i_clk);
        o_sen_n <= 1'b1;
        o_sdio <= ~o_sdio;
        if (rd)
        begin
            o_rd_done <= 1'b1;
            @(negedge i_clk);
            o_rd_done <= 1'b0;
        end
        repeat (5) @(negedge i_clk);
    endtask
endmodule
`default_nettype wire

// >>> testbench.sv
// Self-checking testbench for the serial output framing configuration block
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import sofc_pkg::*;
    logic i_clk;
    logic i_srst;
    logic sclk;
    logic sen_n;
    logic sdio;
    logic sdout;
    logic sdout_oe;
    logic [1:0] decim;
    logic [1:0] lane;
    logic [19:0] user_pat;
    logic [7:0] rdata;
    logic rd_done;
    logic src_sel, div, stretch, half, valid, mism;
    logic [11:0] cur;
    logic [4:0] width;
    logic [19:0] pat;
    logic [7:0] dskew, cskew;
    logic [63:0] cfg_now;
    logic [63:0] q_rd[$];
    logic [63:0] q_cfg[$];
    logic [7:0] regs [4];
    logic [14:0] amap [4] = '{A_FRAME_CLK, A_DRIVE, A_RES, A_TIME};
    logic [7:0] sk [4] = '{SKEW_NONE_PS, SKEW_ADV_PS, SKEW_DEL_PS, SKEW_DEL2_PS};
    logic [2:0] t;
    int seed = 32'h19cc;
    int n_fail = 0;
    int checks = 0;
    event cfg_ev;

    assign cfg_now = {5'h0, src_sel, div, stretch, half, cur, width, valid, pat, dskew, cskew, mism};

    sofc_host_model u_sofc_host_model (.i_clk(i_clk), .i_sdout(sdout), .i_sdout_oe(sdout_oe), .o_sclk(sclk),
        .o_sen_n(sen_n), .o_sdio(sdio), .o_rdata(rdata), .o_rd_done(rd_done));

    sofc_config u_sofc_config (.i_clk(i_clk), .i_srst(i_srst), .i_sclk(sclk), .i_sen_n(sen_n), .i_sdio(sdio),
        .i_decim_mode(decim), .i_lane_mode(lane), .i_user_duty_pattern(user_pat), .o_sdout(sdout),
        .o_sdout_oe(sdout_oe), .o_frame_clock_source_sel(src_sel), .o_frame_clock_divide(div),
        .o_frame_clock_stretch(stretch), .o_half_drive_current(half), .o_drive_current_ua(cur),
        .o_word_width(width), .o_width_code_valid(valid), .o_frame_duty_pattern(pat),
        .o_data_output_skew_ps(dskew), .o_bit_clock_output_skew_ps(cskew), .o_config_mismatch(mism));

    initial
    begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    // Frame clock bits {source, divide, stretch} that suit a mode and lane count
    function automatic logic [2:0] tbl(input logic [1:0] d, input logic [1:0] l);
        return {d == DM_COMPLEX && l != LN_HALF, d != DM_COMPLEX && l == LN_2W, d == DM_COMPLEX && l == LN_HALF};
    endfunction

    function automatic logic [63:0] exp_cfg();
        logic [2:0] c;
        logic [4:0] w;
        logic [19:0] p;
        c = regs[2][5:3];
        w = (c == WS_16) ? W_16 : (c == WS_14) ? W_14 : W_18;
        if (regs[2][6])
            w = W_20;
        else if (decim == DM_BYPASS && !regs[2][7])
            w = W_NATIVE;
        p = user_pat;
        if (decim == DM_BYPASS)
            p = (w == W_20) ? PAT_20 : (w == W_18) ? PAT_18 : (w == W_16) ? PAT_16 : PAT_14;
        return {5'h0, regs[0][7], regs[0][4], regs[0][0], regs[1][6], regs[1][6] ? CUR_HALF_UA : CUR_FULL_UA,
            w, c <= WS_14, p, sk[regs[3][3:2]], sk[regs[3][1:0]],
            {regs[0][7], regs[0][4], regs[0][0]} != tbl(decim, lane)};
    endfunction

    task automatic check(input logic [63:0] exp, input logic [63:0] got);
        checks++;
        if (exp !== got)
        begin
            n_fail++;
            $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic stop_test();
        if (n_fail == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        u_sofc_host_model.xfer(1'b0, a, d);
        for (int k = 0; k < 4; k++)
            if (a == amap[k])
                regs[k] = d;
    endtask

    task automatic rd(input logic [14:0] a);
        logic [7:0] e;
        e = 8'h00;
        for (int k = 0; k < 4; k++)
            if (a == amap[k])
                e = regs[k];
        q_rd.push_back({56'h0, e});
        u_sofc_host_model.xfer(1'b1, a, 8'h00);
    endtask

    task automatic chk_cfg();
        @(negedge i_clk);
        @(negedge i_clk);
        q_cfg.push_back(exp_cfg());
        -> cfg_ev;
    endtask

    task automatic do_reset(input int n);
        i_srst = 1'b1;
        repeat (n) @(negedge i_clk);
        i_srst = 1'b0;
        for (int k = 0; k < 4; k++)
            regs[k] = 8'h00;
        repeat (3) @(negedge i_clk);
    endtask

    // Result monitors take the oldest note whenever a result shows
    always @(posedge i_clk)
        if (rd_done === 1'b1)
            check(q_rd.pop_front(), {56'h0, rdata});

    always @(cfg_ev)
        check(q_cfg.pop_front(), cfg_now);

    initial
    begin
        #400000;
        n_fail++;
        stop_test();
    end

    initial
    begin
        i_srst = 1'b1;
        decim = DM_BYPASS;
        lane = LN_1W;
        user_pat = 20'h0_0000;
        do_reset(6);
        chk_cfg();
        for (int k = 0; k < 4; k++)
            rd(amap[k]);
        for (int k = 0; k < 4; k++)
        begin
            wr(amap[k], 8'($random(seed)));
            rd(amap[k]);
            chk_cfg();
        end
        wr(15'h001c, 8'h5a);
        rd(15'h001c);
        for (int d = 0; d < 3; d++)
            for (int l = 0; l < 3; l++)
            begin
                decim = d[1:0];
                lane = l[1:0];
                t = tbl(decim, lane);
                wr(A_FRAME_CLK, {t[2], 2'b00, t[1], 3'b000, t[0]});
                for (int d2 = 0; d2 < 3; d2++)
                    for (int l2 = 0; l2 < 3; l2++)
                    begin
                        decim = d2[1:0];
                        lane = l2[1:0];
                        chk_cfg();
                    end
            end
        for (int v = 0; v < 32; v++)
        begin
            wr(A_RES, {v[4:0], 3'b000});
            user_pat = 20'($random(seed));
            for (int d = 0; d < 3; d++)
            begin
                decim = d[1:0];
                chk_cfg();
            end
        end
        for (int i = 0; i < 16; i++)
        begin
            wr(A_TIME, i[7:0]);
            wr(A_DRIVE, {1'b0, i[0], 6'b00_0000});
            chk_cfg();
        end
        // Second reset in mid-run must bring every register back to zero
        do_reset(2);
        chk_cfg();
        for (int k = 0; k < 4; k++)
            rd(amap[k]);
        repeat (4) @(negedge i_clk);
        stop_test();
    end
endmodule
`default_nettype wire
